// File: pac_pkg.sv
// constants and carrier types for the activity status and class registers
package pac_pkg;

	////////////////////////////////////////////////////////////////////////
	// i/o port pair: index port and data port
	localparam logic [15:0] PAC_INDEX_PORT = 16'h0022;
	localparam logic [15:0] PAC_DATA_PORT  = 16'h0023;

	////////////////////////////////////////////////////////////////////////
	// register indexes behind the data port
	localparam logic [7:0] PAC_IDX_STAT_A  = 8'h66;
	localparam logic [7:0] PAC_IDX_STAT_B  = 8'h67;
	localparam logic [7:0] PAC_IDX_STAT_C  = 8'h68;
	localparam logic [7:0] PAC_IDX_STAT_D  = 8'h69;
	localparam logic [7:0] PAC_IDX_CLASS_A = 8'h6a;
	localparam logic [7:0] PAC_IDX_CLASS_B = 8'h6b;
	localparam logic [7:0] PAC_IDX_CLASS_C = 8'h6c;

	////////////////////////////////////////////////////////////////////////
	// implemented bits per group; reserved bits read zero
	localparam logic [7:0] PAC_MASK_A    = 8'h7f;
	localparam logic [7:0] PAC_MASK_B    = 8'h3f;
	localparam logic [7:0] PAC_MASK_FULL = 8'hff;

	// group c bits that come from pins
	localparam int PAC_BIT_AC_DETECT = 7;
	localparam int PAC_BIT_RX_TOGGLE = 1;
	localparam int PAC_BIT_RING      = 0;

	// reset values
	localparam logic [7:0] PAC_RST_INDEX = 8'h00;
	localparam logic [7:0] PAC_RST_STAT  = 8'h00;
	localparam logic [7:0] PAC_RST_CLASS = 8'h00;
	localparam logic [7:0] PAC_RST_RDATA = 8'h00;
	localparam logic [7:0] PAC_UNMAPPED  = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// one byte per register group
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
	} pac_grp_s;

	// i/o cycle request, one-cycle strobes on ref_clk
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pac_io_req_s;

	// one-cycle detection strobes from on-chip decode logic
	typedef struct packed {
		logic local_bus_cycle_seen;
		logic upper_rom_select_seen;
		logic rom_select_zero_seen;
		logic graphics_memory_seen;
		logic graphics_io_seen;
		logic second_serial_port_seen;
		logic first_serial_port_seen;
		logic keyboard_register_seen;
		logic keyboard_timer_expiry_seen;
		logic timer_tick_seen;
		logic other_interrupt_seen;
		logic main_memory_seen;
		logic key_press_seen;
		logic dma_request_seen;
		logic hard_drive_port_seen;
		logic floppy_port_seen;
		logic ext_graphics_memory_seen;
		logic ext_graphics_io_seen;
		logic system_register_seen;
		logic card_status_change_seen;
		logic card_ring_seen;
		logic socket_b_io_seen;
		logic socket_b_memory_seen;
		logic socket_a_io_seen;
		logic socket_a_memory_seen;
		logic parallel_port_seen;
	} pac_src_s;

	// all state of the register block
	typedef struct packed {
		logic [7:0] index;
		pac_grp_s   stat;
		logic [7:0] cls_a;
		logic [7:0] cls_b;
		logic [7:0] cls_c;
		logic [7:0] rdata;
		logic       primary;
		logic       secondary;
		logic [1:0] ac_sync;
		logic [1:0] rx_sync;
		logic [1:0] ring_sync;
		logic       rx_prev;
		logic       ring_prev;
	} pac_state_s;

endpackage

// File: pac_activity_regs.sv
// activity status and activity class registers behind the index/data port
`timescale 1ns/1ns
//
// What this block does
// [RULE_01] status bit sets to 1 on detected activity, reads 0 otherwise
// [RULE_02] writing 0 to a status bit clears it
// [RULE_03] class bit 0 means primary activity, 1 means secondary
// [RULE_04] software preserves reserved bits on read-modify-write
// [RULE_05] status a bit 6 records local-bus memory or i/o cycles
// [RULE_06] status a bits 5..0: rom selects, graphics, serial ports
// [RULE_07] status b bit 5 flags keyboard register accesses at 60h/64h
// [RULE_08] status b bit 3 timer tick, bit 2 other interrupts
// [RULE_09] status b bit 4 keyboard timer, bit 1 dram, bit 0 key press
// [RULE_10] status c bits 7..2: ac detect, dma, disks, external graphics
// [RULE_11] status c bit 1 receive toggle, bit 0 ring indicate
// [RULE_12] status d bits 7..5: system registers, card change, card ring
// [RULE_13] status d bits 4..0: socket b, socket a, parallel port
// [RULE_14] class a classifies group a sources at matching positions
// [RULE_15] class b classifies group b sources at matching positions
// [RULE_16] class c classifies ac detect, dma and hard drive sources
// [RULE_17] a source counts as activity only while its enable is 1
// [RULE_18] writing 1 to a status bit leaves it unchanged
// [RULE_19] detection wins over a same-cycle clearing write
//
module pac_activity_regs
	import pac_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire pac_io_req_s io_req,
	output logic [7:0]       io_rdata,
	input  wire pac_src_s    src,
	input  wire pac_grp_s    src_enable,
	input  wire logic [7:0]  card_class,
	input  wire logic        ac_power_detect,
	input  wire logic        serial_rx,
	input  wire logic        serial_ring,
	output logic             primary_activity,
	output logic             secondary_activity
);

	////////////////////////////////////////////////////////////////////////
	// state
	pac_state_s state_q;
	pac_state_s state_d;

	pac_grp_s   det;
	pac_grp_s   hit;
	pac_grp_s   cls;
	logic       rx_fall;
	logic       ring_fall;
	logic       wr_data;
	logic       rd_data;
	logic       wr_index;
	logic       rd_index;
	logic [3:0] clr_grp;
	logic [7:0] rd_mux;
	logic [7:0] nxt_a;
	logic [7:0] nxt_b;
	logic [7:0] nxt_c;
	logic [7:0] nxt_d;
	pac_grp_s   pri_hit;
	pac_grp_s   sec_hit;

	////////////////////////////////////////////////////////////////////////
	// pin edges, taken after the second sync stage only
	assign rx_fall   = state_q.rx_prev & ~state_q.rx_sync[1];
	assign ring_fall = state_q.ring_prev & ~state_q.ring_sync[1];

	// raw detections arranged at their status bit positions
	always_comb begin
		// [RULE_05] local bus cycle
		det.a[7] = 1'b0;
		det.a[6] = src.local_bus_cycle_seen;
		// [RULE_06] rom, graphics, serial
		det.a[5] = src.upper_rom_select_seen;
		det.a[4] = src.rom_select_zero_seen;
		det.a[3] = src.graphics_memory_seen;
		det.a[2] = src.graphics_io_seen;
		det.a[1] = src.second_serial_port_seen;
		det.a[0] = src.first_serial_port_seen;
		// [RULE_07] keyboard registers
		det.b[7:6] = 2'b00;
		det.b[5]   = src.keyboard_register_seen;
		// [RULE_09] keyboard timer expiry
		det.b[4] = src.keyboard_timer_expiry_seen;
		// [RULE_08] tick and other interrupts
		det.b[3] = src.timer_tick_seen;
		det.b[2] = src.other_interrupt_seen;
		// [RULE_09] dram and key press
		det.b[1] = src.main_memory_seen;
		det.b[0] = src.key_press_seen;
		// [RULE_10] power, dma, disks, external graphics
		det.c[PAC_BIT_AC_DETECT] = state_q.ac_sync[1];
		det.c[6] = src.dma_request_seen;
		det.c[5] = src.hard_drive_port_seen;
		det.c[4] = src.floppy_port_seen;
		det.c[3] = src.ext_graphics_memory_seen;
		det.c[2] = src.ext_graphics_io_seen;
		// [RULE_11] serial receive and ring edges
		det.c[PAC_BIT_RX_TOGGLE] = rx_fall;
		det.c[PAC_BIT_RING]      = ring_fall;
		// [RULE_12] system registers, card events
		det.d[7] = src.system_register_seen;
		det.d[6] = src.card_status_change_seen;
		det.d[5] = src.card_ring_seen;
		// [RULE_13] sockets and parallel port
		det.d[4] = src.socket_b_io_seen;
		det.d[3] = src.socket_b_memory_seen;
		det.d[2] = src.socket_a_io_seen;
		det.d[1] = src.socket_a_memory_seen;
		det.d[0] = src.parallel_port_seen;
	end

	////////////////////////////////////////////////////////////////////////
	// [RULE_17] gate by source enables
	always_comb begin
		hit.a = det.a & src_enable.a & PAC_MASK_A;
		hit.b = det.b & src_enable.b & PAC_MASK_B;
		hit.c = det.c & src_enable.c & PAC_MASK_FULL;
		hit.d = det.d & src_enable.d & PAC_MASK_FULL;
	end

	// [RULE_14] class vectors per group
	always_comb begin
		cls.a = state_q.cls_a;
		cls.b = state_q.cls_b;
		cls.c = state_q.cls_c;
		cls.d = card_class;
	end

	// [RULE_03] class 0 sorts a hit as primary, 1 as secondary
	always_comb begin
		pri_hit.a = hit.a & ~cls.a;
		pri_hit.b = hit.b & ~cls.b;
		pri_hit.c = hit.c & ~cls.c;
		pri_hit.d = hit.d & ~cls.d;
		sec_hit.a = hit.a & cls.a;
		sec_hit.b = hit.b & cls.b;
		sec_hit.c = hit.c & cls.c;
		sec_hit.d = hit.d & cls.d;
	end

	////////////////////////////////////////////////////////////////////////
	// i/o decode
	assign wr_data  = io_req.wr && (io_req.addr == PAC_DATA_PORT);
	assign rd_data  = io_req.rd && (io_req.addr == PAC_DATA_PORT);
	assign wr_index = io_req.wr && (io_req.addr == PAC_INDEX_PORT);
	assign rd_index = io_req.rd && (io_req.addr == PAC_INDEX_PORT);

	// read multiplexer on the current index
	always_comb begin
		if (state_q.index == PAC_IDX_STAT_A) begin
			rd_mux = state_q.stat.a;
		end else if (state_q.index == PAC_IDX_STAT_B) begin
			rd_mux = state_q.stat.b;
		end else if (state_q.index == PAC_IDX_STAT_C) begin
			rd_mux = state_q.stat.c;
		end else if (state_q.index == PAC_IDX_STAT_D) begin
			rd_mux = state_q.stat.d;
		end else if (state_q.index == PAC_IDX_CLASS_A) begin
			rd_mux = state_q.cls_a;
		end else if (state_q.index == PAC_IDX_CLASS_B) begin
			rd_mux = state_q.cls_b;
		end else if (state_q.index == PAC_IDX_CLASS_C) begin
			rd_mux = state_q.cls_c;
		end else begin
			rd_mux = PAC_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// [RULE_02] status clear decode, bit 3 is group a
	always_comb begin
		clr_grp = 4'h0;
		if (state_q.index == PAC_IDX_STAT_A) begin
			clr_grp[3] = wr_data;
		end else if (state_q.index == PAC_IDX_STAT_B) begin
			clr_grp[2] = wr_data;
		end else if (state_q.index == PAC_IDX_STAT_C) begin
			clr_grp[1] = wr_data;
		end else if (state_q.index == PAC_IDX_STAT_D) begin
			clr_grp[0] = wr_data;
		end
	end

	// [RULE_19] sticky update per group, set after clear
	pac_sticky_next #(
		.WIDTH (8)
	) stat_a_next (
		.cur    (state_q.stat.a),
		.hit    (hit.a),
		.clr_en (clr_grp[3]),
		.wdata  (io_req.wdata),
		.mask   (PAC_MASK_A),
		.nxt    (nxt_a)
	);

	// group b: keyboard, timer, interrupt, dram sources
	pac_sticky_next #(
		.WIDTH (8)
	) stat_b_next (
		.cur    (state_q.stat.b),
		.hit    (hit.b),
		.clr_en (clr_grp[2]),
		.wdata  (io_req.wdata),
		.mask   (PAC_MASK_B),
		.nxt    (nxt_b)
	);

	// group c: power, dma, disks, graphics, serial pins
	pac_sticky_next #(
		.WIDTH (8)
	) stat_c_next (
		.cur    (state_q.stat.c),
		.hit    (hit.c),
		.clr_en (clr_grp[1]),
		.wdata  (io_req.wdata),
		.mask   (PAC_MASK_FULL),
		.nxt    (nxt_c)
	);

	// group d: system registers, card sockets, parallel port
	pac_sticky_next #(
		.WIDTH (8)
	) stat_d_next (
		.cur    (state_q.stat.d),
		.hit    (hit.d),
		.clr_en (clr_grp[0]),
		.wdata  (io_req.wdata),
		.mask   (PAC_MASK_FULL),
		.nxt    (nxt_d)
	);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_d = state_q;

		// two-stage synchronisers and edge history
		state_d.ac_sync   = {state_q.ac_sync[0], ac_power_detect};
		state_d.rx_sync   = {state_q.rx_sync[0], serial_rx};
		state_d.ring_sync = {state_q.ring_sync[0], serial_ring};
		state_d.rx_prev   = state_q.rx_sync[1];
		state_d.ring_prev = state_q.ring_sync[1];

		// index port write
		if (wr_index) begin
			state_d.index = io_req.wdata;
		end

		// class register writes; reserved class bits are dropped
		if (wr_data) begin
			if (state_q.index == PAC_IDX_CLASS_A) begin
				state_d.cls_a = io_req.wdata & PAC_MASK_A;
			end else if (state_q.index == PAC_IDX_CLASS_B) begin
				// [RULE_15] keyboard and timer classes
				state_d.cls_b = io_req.wdata & PAC_MASK_B;
			end else if (state_q.index == PAC_IDX_CLASS_C) begin
				// [RULE_16] power, dma, disk classes
				state_d.cls_c = io_req.wdata & PAC_MASK_FULL;
			end
		end

		// [RULE_01] sticky status from the per-group update
		state_d.stat.a = nxt_a;
		state_d.stat.b = nxt_b;
		state_d.stat.c = nxt_c;
		state_d.stat.d = nxt_d;

		// [RULE_03] one pulse per class for this cycle's activity
		state_d.primary   = |pri_hit;
		state_d.secondary = |sec_hit;

		// read data captured on the read strobe
		if (rd_data) begin
			state_d.rdata = rd_mux;
		end else if (rd_index) begin
			state_d.rdata = state_q.index;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q.index     <= PAC_RST_INDEX;
			state_q.stat      <= {4{PAC_RST_STAT}};
			state_q.cls_a     <= PAC_RST_CLASS;
			state_q.cls_b     <= PAC_RST_CLASS;
			state_q.cls_c     <= PAC_RST_CLASS;
			state_q.rdata     <= PAC_RST_RDATA;
			state_q.primary   <= 1'b0;
			state_q.secondary <= 1'b0;
			state_q.ac_sync   <= 2'b00;
			state_q.rx_sync   <= 2'b11;
			state_q.ring_sync <= 2'b11;
			state_q.rx_prev   <= 1'b1;
			state_q.ring_prev <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from flip-flops
	assign io_rdata           = state_q.rdata;
	assign primary_activity   = state_q.primary;
	assign secondary_activity = state_q.secondary;

endmodule

////////////////////////////////////////////////////////////////////////////
// next value of one sticky status group
module pac_sticky_next
	import pac_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input  wire logic [WIDTH-1:0] cur,
	input  wire logic [WIDTH-1:0] hit,
	input  wire logic             clr_en,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [WIDTH-1:0] mask,
	output logic      [WIDTH-1:0] nxt
);

	logic [WIDTH-1:0] kept;

	// [RULE_02] zeros written clear
	// [RULE_18] ones written keep
	always_comb begin
		if (clr_en) begin
			kept = cur & wdata;
		end else begin
			kept = cur;
		end
	end

	// [RULE_19] a same-cycle detection sets the bit again
	assign nxt = (kept | hit) & mask;

endmodule

// File: pac_properties.sv
// port assertions for the activity register block, with its bind
`timescale 1ns/1ns
module pac_properties
	import pac_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire pac_io_req_s io_req,
	input wire logic [7:0]  io_rdata,
	input wire pac_src_s    src,
	input wire pac_grp_s    src_enable,
	input wire logic [7:0]  card_class,
	input wire logic        ac_power_detect,
	input wire logic        serial_rx,
	input wire logic        serial_ring,
	input wire logic        primary_activity,
	input wire logic        secondary_activity
);
	logic [25:0] sv;
	logic [7:0]  ha, hb, hc, hd, idx_q;
	logic [2:0]  quiet_q;
	logic        hit, rdd, rdx, quiet, pd, sd;
	// enabled hits per group and decoded reads
	assign sv = src;
	assign ha = {1'b0, sv[25:19]} & src_enable.a;
	assign hb = {2'b00, sv[18:13]} & src_enable.b;
	assign hc = {1'b0, sv[12:8], 2'b00} & src_enable.c;
	assign hd = sv[7:0] & src_enable.d;
	assign hit = (ha | hb | hc | hd) != 8'h00;
	assign pd = (hd & ~card_class) != 8'h00;
	assign sd = (hd & card_class) != 8'h00;
	assign rdd = io_req.rd && io_req.addr == PAC_DATA_PORT;
	assign rdx = io_req.rd && io_req.addr == PAC_INDEX_PORT;
	assign quiet = quiet_q == 3'h4;
	// index shadow and count of idle pin cycles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_q   <= 8'h00;
			quiet_q <= 3'h0;
		end else begin
			if (io_req.wr && io_req.addr == PAC_INDEX_PORT)
				idx_q <= io_req.wdata;
			if (ac_power_detect || !serial_rx || !serial_ring)
				quiet_q <= 3'h0;
			else if (!quiet)
				quiet_q <= quiet_q + 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_quiet_no_pulse: assert property (
		!hit && quiet |=> !primary_activity && !secondary_activity)
		else $error("pulse without enabled hit");
	a_hit_pulses: assert property (
		hit |=> primary_activity || secondary_activity)
		else $error("hit without pulse");
	a_card_primary: assert property (
		pd |=> primary_activity) else $error("primary pulse missing");
	a_card_second: assert property (
		sd |=> secondary_activity) else $error("secondary pulse missing");
	a_rdata_hold: assert property (
		!rdd && !rdx |=> $stable(io_rdata)) else $error("read data moved");
	a_set_wins_d: assert property (
		hd != 8'h00 ##1 rdd && idx_q == PAC_IDX_STAT_D |=>
		(io_rdata & $past(hd, 2)) == $past(hd, 2)) else $error("lost set");
	a_set_shows_c: assert property (
		hc != 8'h00 ##1 rdd && idx_q == PAC_IDX_STAT_C |=>
		(io_rdata & $past(hc, 2)) == $past(hc, 2)) else $error("c not set");
	a_clear_zero: assert property (
		io_req.wr && io_req.addr == PAC_DATA_PORT && io_req.wdata == 8'h00
		&& idx_q == PAC_IDX_STAT_C && hc == 8'h00 && quiet ##1 rdd |=>
		io_rdata == 8'h00) else $error("status not cleared");
	c_primary: cover property (primary_activity);
	c_second: cover property (secondary_activity);
	c_clear: cover property (io_req.wr && io_req.wdata == 8'h00);
endmodule

bind pac_activity_regs pac_properties pac_properties_inst (.ref_clk(ref_clk),
	.arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata), .src(src),
	.src_enable(src_enable), .card_class(card_class),
	.ac_power_detect(ac_power_detect), .serial_rx(serial_rx),
	.serial_ring(serial_ring), .primary_activity(primary_activity),
	.secondary_activity(secondary_activity));

// File: testbench.sv
// self-checking bench with a register model for the activity block
`timescale 1ns/1ns
module testbench
	import pac_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        ac = 1'b0;
	logic        rx = 1'b1;
	logic        ring = 1'b1;
	logic        chk = 1'b1;
	logic        prim, sec, mp, ms;
	logic [7:0]  rdata, mi, mr, d, wd;
	logic [7:0]  cc = 8'h00;
	logic [7:0]  st [4], cl [3], h [4], c [4];
	logic [25:0] sv, rs;
	pac_io_req_s req = '0;
	pac_src_s    src = '0;
	pac_grp_s    en = '0;
	integer      seed = 76, mismatches = 0, cmp_count = 0, n = 0, i, k;

	initial forever #20 ref_clk = ~ref_clk;

	pac_activity_regs pac_activity_regs_inst (.ref_clk(ref_clk),
		.arst_n(arst_n), .io_req(req), .io_rdata(rdata), .src(src),
		.src_enable(en), .card_class(cc), .ac_power_detect(ac),
		.serial_rx(rx), .serial_ring(ring), .primary_activity(prim),
		.secondary_activity(sec));

	// register value seen through the data port
	function automatic logic [7:0] rv(input logic [7:0] x);
		if (x inside {[8'h66:8'h69]})
			return st[x - 8'h66];
		if (x inside {[8'h6a:8'h6c]})
			return cl[x - 8'h6a];
		return 8'h00;
	endfunction

	// reference model, updated at each edge
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st = '{default: 8'h00};
			cl = '{default: 8'h00};
			mi = 8'h00;
			mr = 8'h00;
		end else begin
			sv = src;
			h = '{{1'b0, sv[25:19]} & en.a, {2'b00, sv[18:13]} & en.b,
				{1'b0, sv[12:8], 2'b00} & en.c, sv[7:0] & en.d};
			c = '{cl[0], cl[1], cl[2], cc};
			if (req.rd && req.addr == PAC_INDEX_PORT)
				mr = mi;
			if (req.rd && req.addr == PAC_DATA_PORT)
				mr = rv(mi);
			if (req.wr && req.addr == PAC_DATA_PORT) begin
				if (mi inside {[8'h66:8'h69]})
					st[mi - 8'h66] &= req.wdata;
				if (mi == PAC_IDX_CLASS_A)
					cl[0] = req.wdata & PAC_MASK_A;
				if (mi == PAC_IDX_CLASS_B)
					cl[1] = req.wdata & PAC_MASK_B;
				if (mi == PAC_IDX_CLASS_C)
					cl[2] = req.wdata;
			end
			if (req.wr && req.addr == PAC_INDEX_PORT)
				mi = req.wdata;
			mp = 1'b0;
			ms = 1'b0;
			for (int j = 0; j < 4; j++) begin
				mp |= (h[j] & ~c[j]) != 8'h00;
				ms |= (h[j] & c[j]) != 8'h00;
				st[j] |= h[j];
			end
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one bus cycle with strobes, then compare outputs
	task automatic cyc(input logic w, input logic r, input logic [15:0] a,
		input logic [7:0] wd, input logic [25:0] s);
		req = '{w, r, a, wd};
		src = s;
		@(posedge ref_clk);
		#1;
		check(rdata, mr);
		if (chk) begin
			check({7'h00, prim}, {7'h00, mp});
			check({7'h00, sec}, {7'h00, ms});
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard
	always @(posedge ref_clk) begin
		n++;
		if (n == 10000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		for (i = 8'h64; i < 8'h6e; i++) begin
			cyc(1'b1, 1'b0, PAC_INDEX_PORT, i[7:0], 26'h0);
			cyc(1'b0, 1'b1, PAC_DATA_PORT, 8'h00, 26'h0);
		end
		$display("test done: reset values");
		chk = 1'b0;
		en = '1;
		ac = 1'b1;
		rx = 1'b0;
		ring = 1'b0;
		repeat (5) cyc(1'b0, 1'b0, 16'h0, 8'h00, 26'h0);
		check({7'h00, prim}, 8'h01);
		check({7'h00, sec}, 8'h00);
		ac = 1'b0;
		rx = 1'b1;
		ring = 1'b1;
		repeat (5) cyc(1'b0, 1'b0, 16'h0, 8'h00, 26'h0);
		st[2] |= 8'h83;
		chk = 1'b1;
		cyc(1'b1, 1'b0, PAC_INDEX_PORT, PAC_IDX_STAT_C, 26'h0);
		cyc(1'b0, 1'b1, PAC_DATA_PORT, 8'h00, 26'h0);
		cyc(1'b1, 1'b0, PAC_DATA_PORT, 8'h00, 26'h0);
		cyc(1'b0, 1'b1, PAC_DATA_PORT, 8'h00, 26'h0);
		$display("test done: pin sources");
		for (i = 0; i < 3000; i++) begin
			if (i % 300 == 0) begin
				en = $random(seed);
				cc = 8'($random(seed));
			end
			k = $unsigned($random(seed)) % 8;
			d = 8'($random(seed));
			rs = 26'($random(seed) & $random(seed) & $random(seed));
			wd = d | {d[3:0], d[7:4]};
			// reserved bits written back as they read
			if (mi == PAC_IDX_STAT_A || mi == PAC_IDX_CLASS_A)
				wd &= PAC_MASK_A;
			if (mi == PAC_IDX_STAT_B || mi == PAC_IDX_CLASS_B)
				wd &= PAC_MASK_B;
			if (k < 3 && mi inside {[8'h6a:8'h6c]})
				rs = 26'h0;
			case (k)
				0: cyc(1'b1, 1'b0, PAC_INDEX_PORT, 8'h64 + d % 8'h0a, rs);
				1, 2: cyc(1'b1, 1'b0, PAC_DATA_PORT, wd, rs);
				3: cyc(1'b0, 1'b1, PAC_INDEX_PORT, 8'h00, rs);
				4, 5: cyc(1'b0, 1'b1, PAC_DATA_PORT, 8'h00, rs);
				6: cyc(1'b1, 1'b1, 16'h0021, 8'h00, rs);
				default: cyc(1'b0, 1'b0, 16'h0, 8'h00, rs);
			endcase
		end
		$display("test done: random traffic");
		results();
	end
endmodule
